// [adcmx_top.sv]
// Converter input selection, result placement and DMA configuration core.
`timescale 1ns/1ps
module adcmx_top (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic      [31:0] o_hrdata,
  input  wire logic        i_twelve_bit_mode,
  input  wire logic        i_alternate_mux_select,
  input  wire logic [4:0]  i_increment_rate_field,
  input  wire logic [2:0]  i_opamp_enable,
  input  wire logic        i_sample_active,
  input  wire logic        i_conv_done,
  input  wire logic [15:0] i_conv_result,
  output logic      [19:0] o_pos_src,
  output logic      [19:0] o_neg_src,
  output logic             o_mux_set_b,
  output logic             o_dma_request,
  output logic             o_dma_addr_inc,
  output logic      [7:0]  o_dma_buffer_words
);

  // ----------------------------------------------------------------
  // Bus slave and register strobes
  // ----------------------------------------------------------------
  adcmx_reg_if regs ();

  adcmx_ahb_slave u_slave (
    .i_clk    (i_clk),
    .i_nrst   (i_nrst),
    .i_hsel   (i_hsel),
    .i_haddr  (i_haddr),
    .i_htrans (i_htrans),
    .i_hwrite (i_hwrite),
    .i_hready (i_hready),
    .i_hwdata (i_hwdata),
    .regs     (regs)
  );

  logic [15:0]         dma_ctrl;
  logic [15:0]         multi_sel;
  logic [15:0]         ch0_sel;
  logic                sample_q;
  logic                use_b;
  logic [3:0]          fill_ptr;
  logic [4:0]          conv_cnt;
  logic [15:0]         buf_rdata;
  adcmx_pkg::adcmx_smp_type smp_st;

  // The size field is not checked: every access is treated as a whole word.
  wire        size_unused = |i_hsize;
  wire        wr_dma    = regs.wr & (regs.waddr == adcmx_pkg::DMA_CTRL_OFS);
  wire        wr_multi  = regs.wr & (regs.waddr == adcmx_pkg::MULTI_SEL_OFS)
                          & ~i_twelve_bit_mode;
  wire        wr_ch0    = regs.wr & (regs.waddr == adcmx_pkg::CH0_SEL_OFS);
  wire        dma_en    = dma_ctrl[adcmx_pkg::DMA_EN_BIT];
  wire [2:0]  depth     = dma_ctrl[adcmx_pkg::DEPTH_LSB +: 3];
  // Twelve-bit mode hides the channel 1 to 3 fields without losing them.
  wire [15:0] multi_eff = i_twelve_bit_mode ? 16'h0000 : multi_sel;
  wire        rd_mem    = regs.raddr[7:6] == adcmx_pkg::RESULT_BASE[7:6];

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  // Masks clear every unimplemented position, unmapped addresses read zero.
  wire [15:0] reg_word =
    (regs.raddr == adcmx_pkg::DMA_CTRL_OFS)  ? dma_ctrl  :
    (regs.raddr == adcmx_pkg::MULTI_SEL_OFS) ? multi_eff :
    (regs.raddr == adcmx_pkg::CH0_SEL_OFS)   ? ch0_sel   : 16'h0000;

  // Control registers keep only their implemented bits.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dma_ctrl  <= adcmx_pkg::DMA_CTRL_RST;
      multi_sel <= adcmx_pkg::MULTI_SEL_RST;
      ch0_sel   <= adcmx_pkg::CH0_SEL_RST;
    end else begin
      if (wr_dma)   dma_ctrl  <= regs.wdata & adcmx_pkg::DMA_CTRL_MASK;
      if (wr_multi) multi_sel <= regs.wdata & adcmx_pkg::MULTI_SEL_MASK;
      if (wr_ch0)   ch0_sel   <= regs.wdata & adcmx_pkg::CH0_SEL_MASK;
    end
  end

  // Bus response is ready and OKAY from the first edge after reset (not ready in reset); no access needs a wait state.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_hreadyout <= 1'b0;
      o_hresp     <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp     <= size_unused & 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Input selection for sets A and B
  // ----------------------------------------------------------------
  wire       sel_b     = i_alternate_mux_select & use_b;
  wire [4:0] ch0p_code = sel_b ? ch0_sel[adcmx_pkg::CH0_SB_LSB +: 5]
                               : ch0_sel[adcmx_pkg::CH0_SA_LSB +: 5];
  wire       ch0n_bit  = sel_b ? ch0_sel[adcmx_pkg::CH0_NB_BIT]
                               : ch0_sel[adcmx_pkg::CH0_NA_BIT];
  wire       mp_bit    = sel_b ? multi_eff[adcmx_pkg::MULTI_SB_BIT]
                               : multi_eff[adcmx_pkg::MULTI_SA_BIT];
  wire [1:0] mn_code   = sel_b ? multi_eff[adcmx_pkg::MULTI_NB_LSB +: 2]
                               : multi_eff[adcmx_pkg::MULTI_NA_LSB +: 2];
  // Channel 0 negative is input 1 or the low reference.
  wire [4:0] ch0n_src  = ch0n_bit ? 5'h01 : adcmx_pkg::SRC_LOW_REFERENCE_VOLTAGE;
  wire [19:0] next_pos = {adcmx_pkg::multi_pos(2'h2, mp_bit, i_opamp_enable),
                          adcmx_pkg::multi_pos(2'h1, mp_bit, i_opamp_enable),
                          adcmx_pkg::multi_pos(2'h0, mp_bit, i_opamp_enable),
                          adcmx_pkg::ch0_pos(ch0p_code, i_opamp_enable)};
  wire [19:0] next_neg = {adcmx_pkg::multi_neg(2'h2, mn_code, i_opamp_enable),
                          adcmx_pkg::multi_neg(2'h1, mn_code, i_opamp_enable),
                          adcmx_pkg::multi_neg(2'h0, mn_code, i_opamp_enable),
                          ch0n_src};
  wire        smp_start = i_sample_active & ~sample_q;
  wire        smp_end   = ~i_sample_active & sample_q;

  // Codes are captured at the start of sampling and frozen until it ends, so
  // a register write during sampling only affects the next sample.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sample_q    <= 1'b0;
      smp_st      <= adcmx_pkg::SMP_IDLE;
      o_pos_src   <= 20'h0_0000;
      o_neg_src   <= 20'h0_0000;
      o_mux_set_b <= 1'b0;
    end else begin
      sample_q <= i_sample_active;
      case (smp_st)
        adcmx_pkg::SMP_IDLE: begin
          if (smp_start) begin
            smp_st      <= adcmx_pkg::SMP_HOLD;
            o_pos_src   <= next_pos;
            o_neg_src   <= next_neg;
            o_mux_set_b <= sel_b;
          end
        end
        adcmx_pkg::SMP_HOLD: begin
          if (smp_end) smp_st <= adcmx_pkg::SMP_IDLE;
        end
        default: smp_st <= adcmx_pkg::SMP_IDLE;
      endcase
    end
  end

  // Set A goes first; with alternation on, each finished sample flips the set.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      use_b <= 1'b0;
    end else if (!i_alternate_mux_select) begin
      use_b <= 1'b0;
    end else if (smp_end) begin
      use_b <= ~use_b;
    end
  end

  // ----------------------------------------------------------------
  // Result placement and DMA pacing
  // ----------------------------------------------------------------
  wire [3:0] res_waddr = dma_en ? 4'h0 : fill_ptr;
  wire       rate_hit  = conv_cnt == i_increment_rate_field;

  adcmx_result_buffer u_buf (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .i_we      (i_conv_done),
    .i_waddr   (res_waddr),
    .i_wdata   (i_conv_result),
    .i_re      (regs.rd),
    .i_mem_sel (rd_mem),
    .i_raddr   (regs.raddr[5:2]),
    .i_bypass  (reg_word),
    .o_rdata   (buf_rdata)
  );

  assign o_hrdata = {16'h0000, buf_rdata};

  // The fill pointer only walks when DMA is off; enabling DMA rewinds it.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fill_ptr <= 4'h0;
    end else if (dma_en) begin
      fill_ptr <= 4'h0;
    end else if (i_conv_done) begin
      fill_ptr <= fill_ptr + 4'h1;
    end
  end

  // Address increments every rate+1 conversions; the request fires each one.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      conv_cnt           <= 5'h00;
      o_dma_request      <= 1'b0;
      o_dma_addr_inc     <= 1'b0;
      o_dma_buffer_words <= 8'h01;
    end else begin
      o_dma_request      <= dma_en & i_conv_done;
      o_dma_addr_inc     <= dma_en & i_conv_done & rate_hit;
      o_dma_buffer_words <= 8'h01 << depth;
      if (!dma_en) begin
        conv_cnt <= 5'h00;
      end else if (i_conv_done) begin
        conv_cnt <= rate_hit ? 5'h00 : conv_cnt + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence sample_opened;
    smp_start && smp_st == adcmx_pkg::SMP_IDLE;
  endsequence
  sequence sample_held;
    smp_st == adcmx_pkg::SMP_HOLD && i_sample_active;
  endsequence

  // Result placement: one slot under DMA, the walking fill pointer otherwise.
  dma_single_slot_a: assert property (
    i_conv_done && dma_en |-> res_waddr == 4'h0 ##1 o_dma_request)
    else $error("dma result not placed in first slot");
  fill_walk_a: assert property (
    i_conv_done && !dma_en |=> fill_ptr == $past(fill_ptr) + 4'h1 || dma_en)
    else $error("fill pointer did not advance");
  dma_off_quiet_a: assert property (
    !dma_en |=> !o_dma_request)
    else $error("dma request raised with result dma off");
  depth_words_a: assert property (
    ##1 o_dma_buffer_words == (8'h01 << $past(depth)))
    else $error("buffer words not two to the depth");

  // Register view: hidden fields read zero and refuse writes while hidden.
  twelve_hidden_a: assert property (
    regs.rd && regs.raddr == adcmx_pkg::MULTI_SEL_OFS && i_twelve_bit_mode
    |=> o_hrdata == 32'h0000_0000)
    else $error("channel 1-3 selects visible in twelve-bit mode");
  twelve_write_a: assert property (
    regs.wr && regs.waddr == adcmx_pkg::MULTI_SEL_OFS && i_twelve_bit_mode
    |=> $stable(multi_sel))
    else $error("channel 1-3 selects written in twelve-bit mode");
  reserved_zero_a: assert property (
    regs.rd && regs.raddr == adcmx_pkg::CH0_SEL_OFS
    |=> o_hrdata[14:13] == 2'h0 && o_hrdata[6:5] == 2'h0)
    else $error("unimplemented bits read nonzero");

  // Set choice is made once, at the start of each sample.
  set_a_only_a: assert property (
    sample_opened and !i_alternate_mux_select |=> !o_mux_set_b)
    else $error("set B used without alternation");
  set_b_turn_a: assert property (
    sample_opened and i_alternate_mux_select && use_b |=> o_mux_set_b)
    else $error("set B not used on its turn");

  // Captured codes against the fixed encodings; enables count at sample start.
  ch0_neg_ref_a: assert property (
    sample_opened and !ch0n_bit |=> o_neg_src[4:0] == adcmx_pkg::SRC_LOW_REFERENCE_VOLTAGE)
    else $error("channel 0 negative not low reference");
  ch0_neg_in1_a: assert property (
    sample_opened and ch0n_bit |=> o_neg_src[4:0] == 5'h01)
    else $error("channel 0 negative not input 1");
  ch0_plain_a: assert property (
    sample_opened and !ch0p_code[4] |=> o_pos_src[4:0] == $past(ch0p_code))
    else $error("channel 0 positive not the plain input");
  ch0_temp_a: assert property (
    sample_opened and ch0p_code == 5'h1E |=> o_pos_src[4:0] == adcmx_pkg::SRC_TEMP)
    else $error("channel 0 positive not the temperature diode");
  ch0_oa1_a: assert property (
    sample_opened and ch0p_code == 5'h18
    |=> o_pos_src[4:0] == ($past(i_opamp_enable[0]) ? adcmx_pkg::SRC_OA1 : 5'h03))
    else $error("op-amp 1 routing ignores its enable");
  multi_pos_lo_a: assert property (
    sample_opened and !mp_bit |=> o_pos_src[19:10] == {5'h02, 5'h01})
    else $error("channel 2-3 positive not inputs 1 and 2");
  multi_neg_hi_a: assert property (
    sample_opened and mn_code == 2'h3 |=> o_neg_src[19:5] == {5'h0B, 5'h0A, 5'h09})
    else $error("channel 1-3 negative not inputs 9 to 11");
  multi_neg_ref_a: assert property (
    sample_opened and !mn_code[1] |=> o_neg_src[19:5] == {3{adcmx_pkg::SRC_LOW_REFERENCE_VOLTAGE}})
    else $error("channel 1-3 negative not low reference");
  codes_hold_a: assert property (
    sample_opened ##1 sample_held[*2] |-> $stable(o_pos_src) && $stable(o_neg_src))
    else $error("input codes moved during sampling");

  // DMA pacing: the increment comes only on the counted conversion.
  rate_inc_a: assert property (
    dma_en && i_conv_done && conv_cnt == i_increment_rate_field
    |=> o_dma_addr_inc ##1 !o_dma_addr_inc || o_dma_request)
    else $error("dma address increment missed");
  rate_skip_a: assert property (
    dma_en && i_conv_done && !rate_hit |=> !o_dma_addr_inc)
    else $error("dma address increment too early");

endmodule // adcmx_top

// [adcmx_pkg.sv]
// Constants, source encodings and input-routing functions of the converter input configuration.
package adcmx_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0]  DMA_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  MULTI_SEL_OFS  = 8'h04;
  localparam logic [7:0]  CH0_SEL_OFS    = 8'h08;
  localparam logic [7:0]  RESULT_BASE    = 8'h40;
  localparam int          RESULT_WORDS   = 16;
  localparam int          DMA_EN_BIT     = 8;
  localparam int          DEPTH_LSB      = 0;
  localparam int          MULTI_NB_LSB   = 9;
  localparam int          MULTI_SB_BIT   = 8;
  localparam int          MULTI_NA_LSB   = 1;
  localparam int          MULTI_SA_BIT   = 0;
  localparam int          CH0_NB_BIT     = 15;
  localparam int          CH0_SB_LSB     = 8;
  localparam int          CH0_NA_BIT     = 7;
  localparam int          CH0_SA_LSB     = 0;
  localparam logic [15:0] DMA_CTRL_MASK  = 16'h0107;
  localparam logic [15:0] MULTI_SEL_MASK = 16'h0707;
  localparam logic [15:0] CH0_SEL_MASK   = 16'h9F9F;
  localparam logic [15:0] DMA_CTRL_RST   = 16'h0000;
  localparam logic [15:0] MULTI_SEL_RST  = 16'h0000;
  localparam logic [15:0] CH0_SEL_RST    = 16'h0000;

  // ----------------------------------------------------------------
  // Source codes presented to the analog front end
  // ----------------------------------------------------------------
  // Codes 0 to 15 are the plain analog inputs of the same number.
  localparam logic [4:0]  SRC_OA1   = 5'h10;
  localparam logic [4:0]  SRC_LOW_REFERENCE_VOLTAGE = 5'h13;
  localparam logic [4:0]  SRC_TEMP  = 5'h14;
  localparam logic [4:0]  SRC_OPEN  = 5'h15;
  localparam logic [4:0]  SRC_RSVD  = 5'h1F;

  typedef enum logic {SMP_IDLE, SMP_HOLD} adcmx_smp_type;

  // Op-amp output only when that op-amp is enabled, else the shared pin.
  function automatic logic [4:0] oa_or_an(input logic [1:0] idx, input logic [4:0] an,
                                          input logic [2:0] en);
    oa_or_an = en[idx] ? SRC_OA1 + {3'h0, idx} : an;
  endfunction

  // Channel 0 positive input decode.
  function automatic logic [4:0] ch0_pos(input logic [4:0] code, input logic [2:0] en);
    case (code)
      5'h18:   ch0_pos = oa_or_an(2'h0, 5'h03, en);
      5'h19:   ch0_pos = oa_or_an(2'h1, 5'h00, en);
      5'h1A:   ch0_pos = oa_or_an(2'h2, 5'h06, en);
      5'h1E:   ch0_pos = SRC_TEMP;
      5'h1F:   ch0_pos = SRC_OPEN;
      default: ch0_pos = code[4] ? SRC_RSVD : code;
    endcase
  endfunction

  // Channels 1 to 3 positive input decode; ch is 0, 1 or 2 for channels 1, 2, 3.
  function automatic logic [4:0] multi_pos(input logic [1:0] ch, input logic sel,
                                           input logic [2:0] en);
    if (sel) begin
      multi_pos = (ch == 2'h0) ? oa_or_an(2'h0, 5'h03, en) :
                  (ch == 2'h1) ? oa_or_an(2'h1, 5'h00, en) : oa_or_an(2'h2, 5'h06, en);
    end else begin
      multi_pos = (ch == 2'h0) ? oa_or_an(2'h1, 5'h00, en) : {3'h0, ch};
    end
  endfunction

  // Channels 1 to 3 negative input decode.
  function automatic logic [4:0] multi_neg(input logic [1:0] ch, input logic [1:0] sel,
                                           input logic [2:0] en);
    if (sel == 2'h3) begin
      multi_neg = 5'h09 + {3'h0, ch};
    end else if (sel == 2'h2) begin
      multi_neg = (ch == 2'h0) ? oa_or_an(2'h2, 5'h06, en) : 5'h06 + {3'h0, ch};
    end else begin
      multi_neg = SRC_LOW_REFERENCE_VOLTAGE;
    end
  endfunction

endpackage

// [adcmx_reg_if.sv]
// Register access carrier between the bus slave and the register core.
`timescale 1ns/1ps
interface adcmx_reg_if;
  logic        wr;
  logic        rd;
  logic [7:0]  waddr;
  logic [7:0]  raddr;
  logic [15:0] wdata;

  modport bus  (output wr, output rd, output waddr, output raddr, output wdata);
  modport core (input wr, input rd, input waddr, input raddr, input wdata);
endinterface

// [adcmx_ahb_slave.sv]
// AHB-Lite slave front end: address phase capture and register strobes.
`timescale 1ns/1ps
module adcmx_ahb_slave (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hwdata,
  adcmx_reg_if.bus         regs
);

  logic       wr_pend;
  logic [7:0] wr_addr;
  wire        take = i_hsel & i_htrans[1] & i_hready;

  // ----------------------------------------------------------------
  // Strobes
  // ----------------------------------------------------------------
  // Reads are decoded in the address phase so data is ready in the data phase.
  assign regs.rd    = take & ~i_hwrite;
  assign regs.raddr = i_haddr[7:0];
  assign regs.wr    = wr_pend;
  assign regs.waddr = wr_addr;
  assign regs.wdata = i_hwdata[15:0];

  // A write lands in its data phase, when the master drives the data.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= take & i_hwrite;
      wr_addr <= take ? i_haddr[7:0] : wr_addr;
    end
  end

  write_phase_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    take && i_hwrite |=> regs.wr && regs.waddr == $past(i_haddr[7:0]))
    else $error("write strobe missing after write address phase");

endmodule // adcmx_ahb_slave

// [adcmx_result_buffer.sv]
// Sixteen-word result store with a registered read port and register bypass.
`timescale 1ns/1ps
module adcmx_result_buffer (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_we,
  input  wire logic [3:0]  i_waddr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_re,
  input  wire logic        i_mem_sel,
  input  wire logic [3:0]  i_raddr,
  input  wire logic [15:0] i_bypass,
  output logic      [15:0] o_rdata
);

  logic [15:0] mem [0:15];

  // Storage has no reset; software reads only what conversions wrote.
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // The read register also carries control register reads so the bus
  // data output comes from one flip-flop.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 16'h0000;
    end else if (i_re) begin
      o_rdata <= i_mem_sel ? mem[i_raddr] : i_bypass;
    end
  end

endmodule // adcmx_result_buffer

// [adcmx_top_tb.sv]
// Self-checking bench for the converter input configuration core.
`timescale 1ns/1ps
module adcmx_top_tb;
  // ------------------------------------------------------------
  // Stimulus and observation signals
  // ------------------------------------------------------------
  logic        i_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_hsel = 1'b0;
  logic        i_hwrite = 1'b0;
  logic [1:0]  i_htrans = 2'h0;
  logic [31:0] i_haddr = 32'h0000_0000;
  logic [31:0] i_hwdata = 32'h0000_0000;
  logic        twelve = 1'b0;
  logic        alt = 1'b0;
  logic [4:0]  rate = 5'h00;
  logic [2:0]  en = 3'h5;
  logic        act = 1'b0;
  logic        done = 1'b0;
  logic [15:0] res = 16'h0000;
  logic        hrdy;
  logic        hresp;
  logic [31:0] hrdata;
  logic [19:0] pos;
  logic [19:0] neg;
  logic        setb;
  logic        req;
  logic        inc;
  logic [7:0]  words;
  logic [31:0] q;
  logic        rsp;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          n_req = 0;
  int          n_inc = 0;
  logic [15:0] msk [3] = '{adcmx_pkg::DMA_CTRL_MASK, adcmx_pkg::MULTI_SEL_MASK,
                           adcmx_pkg::CH0_SEL_MASK};
  logic [4:0]  codes [9] = '{5'h00, 5'h05, 5'h0F, 5'h18, 5'h19, 5'h1A, 5'h1E, 5'h1F, 5'h10};

  adcmx_top dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata),
    .i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_twelve_bit_mode(twelve), .i_alternate_mux_select(alt), .i_increment_rate_field(rate),
    .i_opamp_enable(en), .i_sample_active(act), .i_conv_done(done), .i_conv_result(res),
    .o_pos_src(pos), .o_neg_src(neg), .o_mux_set_b(setb), .o_dma_request(req),
    .o_dma_addr_inc(inc), .o_dma_buffer_words(words));

  // The clock is free running; 100 ns period.
  initial begin
    forever #50 i_clk = ~i_clk;
  end

  // Pulse outputs are counted rather than caught one by one, so no pulse slips past.
  always @(posedge i_clk) begin
    if (req === 1'b1) n_req <= n_req + 1;
    if (inc === 1'b1) n_inc <= n_inc + 1;
  end

  // ------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------
  task report_and_stop;
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits for hready at a rising edge; a bounded count stops a hung bus.
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (hrdy !== 1'b1 && n < 20);
    if (hrdy !== 1'b1) begin
      n_mismatch++;
      report_and_stop;
    end
  endtask

  // One single word transfer, then an idle cycle so a read never follows a write at once.
  task bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= {24'h00_0000, a};
    i_hwrite <= w;
    wait_rdy;
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= {16'h0000, d};
    wait_rdy;
    q = hrdata;
    rsp = hresp;
    @(posedge i_clk);
  endtask

  task rd_chk(input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(q, {16'h0000, e});
    chk({31'h0, rsp}, 32'h0000_0000);
  endtask

  task samp;
    act <= 1'b1;
    repeat (3) @(posedge i_clk);
    act <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask

  task pulse(input logic [15:0] v);
    done <= 1'b1;
    res <= v;
    @(posedge i_clk);
    done <= 1'b0;
    @(posedge i_clk);
  endtask

  // ------------------------------------------------------------
  // Expected source codes
  // ------------------------------------------------------------
  function automatic logic [4:0] oa(input logic [1:0] k, input logic [4:0] an);
    oa = en[k] ? 5'h10 + {3'h0, k} : an;
  endfunction

  function automatic logic [4:0] e_ch0(input logic [4:0] c);
    case (c)
      5'h18:   e_ch0 = oa(2'h0, 5'h03);
      5'h19:   e_ch0 = oa(2'h1, 5'h00);
      5'h1A:   e_ch0 = oa(2'h2, 5'h06);
      5'h1E:   e_ch0 = 5'h14;
      5'h1F:   e_ch0 = 5'h15;
      default: e_ch0 = c[4] ? 5'h1F : c;
    endcase
  endfunction

  function automatic logic [14:0] e_mp(input logic s);
    e_mp = s ? {oa(2'h2, 5'h06), oa(2'h1, 5'h00), oa(2'h0, 5'h03)}
             : {5'h02, 5'h01, oa(2'h1, 5'h00)};
  endfunction

  function automatic logic [14:0] e_mn(input logic [1:0] n);
    e_mn = (n == 2'h3) ? {5'h0B, 5'h0A, 5'h09} :
           (n == 2'h2) ? {5'h08, 5'h07, oa(2'h2, 5'h06)} : {5'h13, 5'h13, 5'h13};
  endfunction

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (2) @(posedge i_clk);
    for (int i = 0; i < 3; i++) begin
      rd_chk(8'(4 * i), 16'h0000);
      bus(1'b1, 8'(4 * i), 16'hFFFF);
      rd_chk(8'(4 * i), msk[i]);
    end
    rd_chk(8'h20, 16'h0000);
    for (int d = 0; d < 8; d++) begin
      bus(1'b1, adcmx_pkg::DMA_CTRL_OFS, 16'(d));
      // The word count follows the register one edge later.
      @(posedge i_clk);
      chk({24'h00_0000, words}, 32'h0000_0001 << d);
    end
    // Without DMA the results fill successive result words and raise no request.
    for (int k = 0; k < 3; k++) pulse(16'hA000 + 16'(k));
    for (int k = 0; k < 3; k++) rd_chk(8'h40 + 8'(4 * k), 16'hA000 + 16'(k));
    chk(32'(n_req), 32'h0000_0000);
    rate <= 5'h01;
    bus(1'b1, adcmx_pkg::DMA_CTRL_OFS, 16'h0100);
    for (int k = 0; k < 4; k++) pulse(16'hB000 + 16'(k));
    // The last pulse is counted at the edge the task returns on.
    @(posedge i_clk);
    chk(32'(n_req), 32'h0000_0004);
    chk(32'(n_inc), 32'h0000_0002);
    rd_chk(8'h40, 16'hB003);
    rd_chk(8'h44, 16'hA001);
    for (int k = 0; k < 9; k++) begin
      bus(1'b1, adcmx_pkg::CH0_SEL_OFS, {8'h00, 3'h4, codes[k]});
      samp;
      chk({27'h0, pos[4:0]}, {27'h0, e_ch0(codes[k])});
      chk({27'h0, neg[4:0]}, 32'h0000_0001);
    end
    // A register write inside a sampling interval must not reach the held codes.
    act <= 1'b1;
    bus(1'b1, adcmx_pkg::CH0_SEL_OFS, 16'h0005);
    chk({27'h0, pos[4:0]}, 32'h0000_001F);
    act <= 1'b0;
    bus(1'b1, adcmx_pkg::CH0_SEL_OFS, 16'h1E82);
    bus(1'b1, adcmx_pkg::MULTI_SEL_OFS, 16'h0700);
    alt <= 1'b1;
    samp;
    chk({31'h0, setb}, 32'h0000_0000);
    chk({27'h0, pos[4:0]}, 32'h0000_0002);
    samp;
    chk({31'h0, setb}, 32'h0000_0001);
    chk({27'h0, pos[4:0]}, 32'h0000_0014);
    chk({27'h0, neg[4:0]}, 32'h0000_0013);
    chk({17'h0, pos[19:5]}, {17'h0, e_mp(1'b1)});
    chk({17'h0, neg[19:5]}, {17'h0, e_mn(2'h3)});
    alt <= 1'b0;
    samp;
    chk({31'h0, setb}, 32'h0000_0000);
    for (int e = 0; e < 2; e++) begin
      en <= e ? 3'h2 : 3'h5;
      for (int s = 0; s < 2; s++) begin
        for (int n = 0; n < 4; n++) begin
          bus(1'b1, adcmx_pkg::MULTI_SEL_OFS, {13'h0, 2'(n), 1'(s)});
          samp;
          chk({17'h0, pos[19:5]}, {17'h0, e_mp(1'(s))});
          chk({17'h0, neg[19:5]}, {17'h0, e_mn(2'(n))});
        end
      end
    end
    twelve <= 1'b1;
    rd_chk(adcmx_pkg::MULTI_SEL_OFS, 16'h0000);
    bus(1'b1, adcmx_pkg::MULTI_SEL_OFS, 16'h0000);
    samp;
    chk({17'h0, pos[19:5]}, {17'h0, e_mp(1'b0)});
    chk({17'h0, neg[19:5]}, {17'h0, e_mn(2'h0)});
    twelve <= 1'b0;
    rd_chk(adcmx_pkg::MULTI_SEL_OFS, 16'h0007);
    report_and_stop;
  end
endmodule // adcmx_top_tb
